// ---- core/bdp_pkg.sv ----
// Package for the bulk data port: register map, field layout, timing and carriers
package bdp_pkg;
  // Register map on the plain register port
  localparam logic [7:0] BDP_ADDR_CTRL = 8'h90;
  localparam logic [7:0] BDP_ADDR_PORTRST = 8'h94;
  localparam logic [7:0] BDP_ADDR_STATUS = 8'h98;
  localparam logic [7:0] BDP_ADDR_DATA = 8'h9c;

  // Control register fields
  localparam int BDP_CTRL_DIR_BIT = 0;
  localparam int BDP_CTRL_SYNC_BIT = 1;
  localparam int BDP_CTRL_SCSI_BIT = 2;
  localparam int BDP_CTRL_OFLAG_LSB = 4;
  localparam logic [15:0] BDP_CTRL_RESET = 16'h0000;

  // Port reset register fields
  localparam int BDP_RST_OUT_BIT = 0;
  localparam int BDP_RST_IN_BIT = 1;

  // Status register fields
  localparam int BDP_ST_VALID_BIT = 0;
  localparam int BDP_ST_READY_BIT = 1;
  localparam int BDP_ST_TRI_BIT = 2;
  localparam int BDP_ST_OVF_BIT = 3;
  localparam int BDP_ST_HFLAG_LSB = 4;

  // Widths and depth
  localparam int BDP_DATA_W = 16;
  localparam int BDP_FLAG_W = 3;
  localparam int BDP_FIFO_DEPTH = 8;

  // Clocking: system clock, internal PHY clock and agent clock ceiling
  localparam longint BDP_SYS_CLK_KHZ = 200000;
  localparam longint BDP_PHY_CLK_KHZ = 49152;
  localparam int BDP_ICLK_MAX_MHZ = 40;
  localparam int BDP_PHASE_W = 16;
  localparam logic [BDP_PHASE_W-1:0] BDP_PHASE_INC =
    BDP_PHASE_W'((BDP_PHY_CLK_KHZ * (64'd1 << BDP_PHASE_W)) / BDP_SYS_CLK_KHZ);
  // PHY ticks per half period of the port output clock
  localparam logic [3:0] BDP_OCLK_HALF = 4'h2;
  // Cycles after reset release before the strap level has crossed the synchroniser
  localparam logic [1:0] BDP_STRAP_WAIT = 2'h3;

  typedef struct packed {
    logic [BDP_FLAG_W-1:0] flags;
    logic [BDP_DATA_W-1:0] data;
  } bdp_word_t;

  typedef struct packed {
    logic [BDP_FLAG_W-1:0] oflags;
    logic scsi_mode;
    logic sync_mode;
    logic dir_out;
  } bdp_ctrl_t;
endpackage

// ---- core/bdp_fifo.sv ----
// Flip-flop FIFO with valid/ready on both sides and a synchronous flush
`timescale 1ns/1ps
`default_nettype none
module bdp_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, next_wr_ptr;
  logic [AW-1:0] rd_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o && !flush_i;
  assign pop = out_valid_o && out_ready_i && !flush_i;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (flush_i) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
    end else begin
      if (push) begin
        next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage carries no reset; out_data_o shows the slot at rd_ptr even while the FIFO is empty
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// ---- core/bdp_dma_port.sv ----
// Bulk data DMA port: pin handshakes, port clocking, register port and word FIFO
//
// Notes on behaviour
// - In asynchronous mode the input clock is ignored; the output clock times the port.
// - The port output clock is derived from the internal 49.152 MHz PHY clock.
// - Output clock disable high stops the port output clock being driven.
// - Tristate select high keeps busy, available and ATAPI acknowledge undriven initially.
// - Writing either port reset bit at 94h starts driving those three outputs.
// - In SCSI mode the available pin shows the direction bit 0 of 90h.
// - The device marks each outgoing word's stream position on the output flags; here they carry bits 6:4 of 90h as set when software wrote the word.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bdp_dma_port
  import bdp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Port clocking and strap pins
  input wire logic port_input_clock_i,
  input wire logic output_clock_disable_i,
  input wire logic port_tristate_select_i,
  output logic port_output_clock_o,
  output logic port_output_clock_oe_o,
  // Handshake pins
  input wire logic port_input_enable_i,
  input wire logic port_output_enable_i,
  input wire logic port_dma_ack_in_i,
  output logic port_input_busy_o,
  output logic port_input_busy_oe_o,
  output logic port_output_available_o,
  output logic port_output_available_oe_o,
  output logic atapi_ack_out_o,
  output logic atapi_ack_out_oe_o,
  // Data and order flags
  input wire logic [BDP_DATA_W-1:0] port_data_lanes_i,
  output logic [BDP_DATA_W-1:0] port_data_lanes_o,
  output logic port_data_lanes_oe_o,
  input wire logic [BDP_FLAG_W-1:0] input_order_flags_i,
  output logic [BDP_FLAG_W-1:0] output_order_flags_o
);
  localparam int PIN_W = 6 + BDP_DATA_W + BDP_FLAG_W;

  // Two-flop synchronisers for every pin input
  logic [PIN_W-1:0] pin_meta, pin_sync;
  logic iclk_s, ocdis_s, tri_s, ien_s, dack_s, oen_s, ien_any;
  logic [BDP_DATA_W-1:0] lanes_s;
  logic [BDP_FLAG_W-1:0] iflags_s;
  logic iclk_prev;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
      iclk_prev <= 1'b0;
    end else begin
      pin_meta <= {port_input_clock_i, output_clock_disable_i, port_tristate_select_i,
                   port_input_enable_i, port_dma_ack_in_i, port_output_enable_i,
                   port_data_lanes_i, input_order_flags_i};
      pin_sync <= pin_meta;
      iclk_prev <= iclk_s;
    end
  end
  assign {iclk_s, ocdis_s, tri_s, ien_s, dack_s, oen_s, lanes_s, iflags_s} = pin_sync;
  // Either qualifier admits a word; combined only after both are synchronised
  assign ien_any = ien_s || dack_s;

  // Control state
  bdp_ctrl_t ctrl, next_ctrl;
  logic tri_hold, next_tri_hold;
  // Strap wait counter, pin drive and registered clock pin
  logic [1:0] strap_wait, next_strap_wait;
  logic drive_q, next_drive_q;
  logic oclk_pin_q, next_oclk_pin_q;
  logic overflow, next_overflow;
  logic [BDP_PHASE_W-1:0] phase, next_phase;
  logic [3:0] oclk_cnt, next_oclk_cnt;
  logic oclk, next_oclk;
  logic [15:0] rdata, next_rdata;
  logic busy_q, next_busy_q;
  logic avail_q, next_avail_q;
  logic ack_q, next_ack_q;
  logic [BDP_DATA_W-1:0] dout_q, next_dout_q;
  logic [BDP_FLAG_W-1:0] oflags_q, next_oflags_q;
  logic dout_oe_q, next_dout_oe_q;
  logic oclk_oe_q, next_oclk_oe_q;

  // FIFO hookup
  bdp_word_t fifo_in, fifo_out;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_flush;

  // Port timing and qualifiers
  logic phy_tick, oclk_rise, port_tick, take_in, give_out;
  logic sw_wr_data, sw_rd_data, port_reset;

  always_comb begin
    logic [BDP_PHASE_W:0] phase_sum;
    phase_sum = {1'b0, phase} + {1'b0, BDP_PHASE_INC};
    phy_tick = phase_sum[BDP_PHASE_W];
    oclk_rise = phy_tick && (oclk_cnt == BDP_OCLK_HALF - 4'h1) && !oclk;
    // Synchronous mode times the port from the agent's clock, else from our own
    port_tick = ctrl.sync_mode ? (iclk_s && !iclk_prev)
                               : oclk_rise;
    sw_wr_data = reg_wr_i && (reg_addr_i == BDP_ADDR_DATA);
    sw_rd_data = reg_rd_i && (reg_addr_i == BDP_ADDR_DATA);
    port_reset = reg_wr_i && (reg_addr_i == BDP_ADDR_PORTRST) &&
                 (reg_wdata_i[BDP_RST_OUT_BIT] || reg_wdata_i[BDP_RST_IN_BIT]);
    // Agent words enter only while not busy; device words leave only when offered
    take_in = !ctrl.dir_out && port_tick && ien_any && fifo_in_ready;
    give_out = ctrl.dir_out && port_tick && oen_s && fifo_out_valid;
  end

  // The FIFO fills from the pins or from software, by direction
  always_comb begin
    fifo_flush = port_reset;
    if (ctrl.dir_out) begin
      fifo_in_valid = sw_wr_data;
      fifo_in.data = reg_wdata_i;
      fifo_in.flags = ctrl.oflags;
      fifo_out_ready = give_out;
    end else begin
      fifo_in_valid = take_in;
      fifo_in.data = lanes_s;
      fifo_in.flags = iflags_s;
      fifo_out_ready = sw_rd_data;
    end
  end

  bdp_fifo #(
    .WIDTH($bits(bdp_word_t)),
    .DEPTH(BDP_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .flush_i(fifo_flush),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out)
  );

  always_comb begin
    next_ctrl = ctrl;
    next_tri_hold = tri_hold;
    next_strap_wait = strap_wait;
    next_overflow = overflow;
    next_phase = phase + BDP_PHASE_INC;
    next_oclk_cnt = oclk_cnt;
    next_oclk = oclk;
    next_rdata = 16'h0000;

    // Strap read once, after its level has crossed both synchroniser stages;
    // until then the handshake outputs stay undriven as a safe default
    if (strap_wait != 2'h0) begin
      next_strap_wait = strap_wait - 2'h1;
    end
    if (strap_wait == 2'h1) begin
      next_tri_hold = tri_s;
    end
    // Software release is final, even inside the strap window
    if (port_reset) begin
      next_tri_hold = 1'b0;
      next_strap_wait = 2'h0;
      next_overflow = 1'b0;
    end

    if (reg_wr_i && reg_addr_i == BDP_ADDR_CTRL) begin
      next_ctrl.dir_out = reg_wdata_i[BDP_CTRL_DIR_BIT];
      next_ctrl.sync_mode = reg_wdata_i[BDP_CTRL_SYNC_BIT];
      next_ctrl.scsi_mode = reg_wdata_i[BDP_CTRL_SCSI_BIT];
      next_ctrl.oflags = reg_wdata_i[BDP_CTRL_OFLAG_LSB +: BDP_FLAG_W];
    end
    // Lost words are flagged; set wins over a same-cycle clear
    if ((sw_wr_data && (!ctrl.dir_out || !fifo_in_ready)) ||
        (!ctrl.dir_out && port_tick && ien_any && !fifo_in_ready)) begin
      next_overflow = 1'b1;
    end

    // Output clock: half period counted in PHY ticks
    if (phy_tick) begin
      if (oclk_cnt == BDP_OCLK_HALF - 4'h1) begin
        next_oclk_cnt = 4'h0;
        next_oclk = !oclk;
      end else begin
        next_oclk_cnt = oclk_cnt + 4'h1;
      end
    end

    if (reg_rd_i) begin
      case (reg_addr_i)
        BDP_ADDR_CTRL: begin
          next_rdata[BDP_CTRL_DIR_BIT] = ctrl.dir_out;
          next_rdata[BDP_CTRL_SYNC_BIT] = ctrl.sync_mode;
          next_rdata[BDP_CTRL_SCSI_BIT] = ctrl.scsi_mode;
          next_rdata[BDP_CTRL_OFLAG_LSB +: BDP_FLAG_W] = ctrl.oflags;
        end
        BDP_ADDR_STATUS: begin
          next_rdata[BDP_ST_VALID_BIT] = fifo_out_valid;
          next_rdata[BDP_ST_READY_BIT] = fifo_in_ready;
          next_rdata[BDP_ST_TRI_BIT] = tri_hold;
          next_rdata[BDP_ST_OVF_BIT] = overflow;
          next_rdata[BDP_ST_HFLAG_LSB +: BDP_FLAG_W] = fifo_out.flags;
        end
        BDP_ADDR_DATA: begin
          // Head word while receiving; empty FIFO reads zero
          if (!ctrl.dir_out && fifo_out_valid) begin
            next_rdata = fifo_out.data;
          end
        end
        default: begin
          next_rdata = 16'h0000;
        end
      endcase
    end
  end

  // Pin outputs, all registered
  always_comb begin
    next_oclk_oe_q = !ocdis_s;
    // Gated from next values so the pin keeps the phase of the internal clock
    next_oclk_pin_q = next_oclk && next_oclk_oe_q;
    next_drive_q = !next_tri_hold;
    if (ctrl.scsi_mode) begin
      // Request shows readiness to move a word in the current direction
      next_busy_q = ctrl.dir_out ? fifo_out_valid : fifo_in_ready;
      next_avail_q = ctrl.dir_out;
    end else begin
      next_busy_q = !fifo_in_ready || ctrl.dir_out;
      next_avail_q = ctrl.dir_out && fifo_out_valid;
    end
    next_ack_q = !ctrl.scsi_mode && (take_in || give_out);
    next_dout_q = fifo_out.data;
    next_oflags_q = ctrl.dir_out ? fifo_out.flags : '0;
    next_dout_oe_q = ctrl.dir_out && oen_s;
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= bdp_ctrl_t'(BDP_CTRL_RESET[5:0]);
      tri_hold <= 1'b1;
      strap_wait <= BDP_STRAP_WAIT;
      drive_q <= 1'b0;
      oclk_pin_q <= 1'b0;
      overflow <= 1'b0;
      phase <= '0;
      oclk_cnt <= 4'h0;
      oclk <= 1'b0;
      rdata <= 16'h0000;
      busy_q <= 1'b1;
      avail_q <= 1'b0;
      ack_q <= 1'b0;
      dout_q <= '0;
      oflags_q <= '0;
      dout_oe_q <= 1'b0;
      oclk_oe_q <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      tri_hold <= next_tri_hold;
      strap_wait <= next_strap_wait;
      drive_q <= next_drive_q;
      oclk_pin_q <= next_oclk_pin_q;
      overflow <= next_overflow;
      phase <= next_phase;
      oclk_cnt <= next_oclk_cnt;
      oclk <= next_oclk;
      rdata <= next_rdata;
      busy_q <= next_busy_q;
      avail_q <= next_avail_q;
      ack_q <= next_ack_q;
      dout_q <= next_dout_q;
      oflags_q <= next_oflags_q;
      dout_oe_q <= next_dout_oe_q;
      oclk_oe_q <= next_oclk_oe_q;
    end
  end

  // Every pin comes straight from a register, so no gate can glitch it
  assign reg_rdata_o = rdata;
  assign port_output_clock_o = oclk_pin_q;
  assign port_output_clock_oe_o = oclk_oe_q;
  assign port_input_busy_o = busy_q;
  assign port_input_busy_oe_o = drive_q;
  assign port_output_available_o = avail_q;
  assign port_output_available_oe_o = drive_q;
  assign atapi_ack_out_o = ack_q;
  assign atapi_ack_out_oe_o = drive_q;
  assign port_data_lanes_o = dout_q;
  assign port_data_lanes_oe_o = dout_oe_q;
  assign output_order_flags_o = oflags_q;
endmodule
`default_nettype wire

// ---- tb/bdp_dma_port_asserts.sv ----
// Pin-level assertions for the bulk data DMA port
`timescale 1ns/1ps
`default_nettype none
module bdp_dma_port_asserts
  import bdp_pkg::*;
(
  // Clock, reset and register writes
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  // Port pins
  input wire logic output_clock_disable_i,
  input wire logic port_tristate_select_i,
  input wire logic port_output_clock_o,
  input wire logic port_output_clock_oe_o,
  input wire logic port_input_busy_oe_o,
  input wire logic port_output_available_o,
  input wire logic port_output_available_oe_o,
  input wire logic atapi_ack_out_o,
  input wire logic atapi_ack_out_oe_o,
  input wire logic port_data_lanes_oe_o,
  input wire logic [BDP_FLAG_W-1:0] output_order_flags_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Shadow of the control register, so modes can be judged at the pins
  logic [15:0] ctrl_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= 16'h0000;
    end else if (reg_wr_i && reg_addr_i == BDP_ADDR_CTRL) begin
      ctrl_q <= reg_wdata_i;
    end
  end
  // Marks the cycle after a port reset write that releases the handshake pins
  logic release_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      release_q <= 1'b0;
    end else begin
      release_q <= reg_wr_i && reg_addr_i == BDP_ADDR_PORTRST && reg_wdata_i[1:0] != 2'h0;
    end
  end
  a_strap_hold: assert property (
    $rose(port_input_busy_oe_o) |-> !port_tristate_select_i || release_q)
    else $error("handshake pins driven despite tristate strap");
  a_oclk_stops: assert property (
    output_clock_disable_i [*4] |-> !port_output_clock_oe_o && !port_output_clock_o)
    else $error("output clock not stopped");
  a_oclk_half: assert property (
    $rose(port_output_clock_o) && $past(port_output_clock_oe_o) |=>
    (port_output_clock_o || !port_output_clock_oe_o) [*7] ##[1:3] !port_output_clock_o)
    else $error("output clock half period wrong");
  a_async_tick: assert property (
    atapi_ack_out_o && !ctrl_q[1] && ctrl_q == $past(ctrl_q, 2) && port_output_clock_oe_o
    |-> port_output_clock_o) else $error("word moved off the output clock");
  a_ack_pulse: assert property (
    atapi_ack_out_o |=> !atapi_ack_out_o) else $error("acknowledge longer than one cycle");
  a_oe_together: assert property (
    port_input_busy_oe_o == port_output_available_oe_o &&
    port_input_busy_oe_o == atapi_ack_out_oe_o) else $error("handshake enables differ");
  a_release_drive: assert property (
    reg_wr_i && reg_addr_i == BDP_ADDR_PORTRST && reg_wdata_i[1:0] != 2'h0
    |=> ##[0:1] port_input_busy_oe_o) else $error("port reset did not release pins");
  a_scsi_dir: assert property (
    ctrl_q[2] && ctrl_q == $past(ctrl_q) |-> port_output_available_o == ctrl_q[0])
    else $error("available pin not showing direction");
  a_in_quiet: assert property (
    !ctrl_q[0] && ctrl_q == $past(ctrl_q) |-> !port_data_lanes_oe_o && output_order_flags_o == 3'h0)
    else $error("output side active in input direction");
endmodule
bind bdp_dma_port bdp_dma_port_asserts u_bdp_dma_port_asserts (.clk_sys_i, .rst_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .output_clock_disable_i, .port_tristate_select_i,
  .port_output_clock_o, .port_output_clock_oe_o,
  .port_input_busy_oe_o, .port_output_available_o, .port_output_available_oe_o, .atapi_ack_out_o,
  .atapi_ack_out_oe_o, .port_data_lanes_oe_o, .output_order_flags_o);
`default_nettype wire

// ---- tb/bdp_agent_model.sv ----
// Behavioural model of the external DMA agent
`timescale 1ns/1ps
`default_nettype none
module bdp_agent_model
  import bdp_pkg::*;
(
  // Sampling clock and clock run request
  input wire logic clk_sys_i,
  input wire logic iclk_run_i,
  // From the device
  input wire logic busy_i,
  input wire logic ack_i,
  input wire logic lanes_oe_i,
  input wire logic [BDP_DATA_W-1:0] lanes_i,
  input wire logic [BDP_FLAG_W-1:0] oflags_i,
  // Towards the device
  output logic iclk_o,
  output logic ien_o,
  output logic oen_o,
  output logic dack_o,
  output logic [BDP_DATA_W-1:0] lanes_o,
  output logic [BDP_FLAG_W-1:0] flags_o
);
  // 6.25 MHz, parked low between frames
  initial begin
    iclk_o = 1'b0;
    forever begin
      #80;
      iclk_o = iclk_run_i ? ~iclk_o : 1'b0;
    end
  end
  initial begin
    ien_o = 1'b0;
    oen_o = 1'b0;
    dack_o = 1'b0;
    lanes_o = 16'h5a5a;
    flags_o = 3'h2;
  end
  task automatic send(input bdp_word_t w, input logic use_ack, output logic ok);
    int n;
    ok = 1'b0;
    for (n = 0; n < 400 && busy_i; n++) @(posedge clk_sys_i);
    flags_o <= w.flags;
    lanes_o <= w.data;
    if (use_ack) dack_o <= 1'b1;
    else ien_o <= 1'b1;
    for (n = 0; n < 400 && !ok; n++) begin
      @(posedge clk_sys_i);
      ok = ack_i;
    end
    ien_o <= 1'b0;
    dack_o <= 1'b0;
    // Released lines show no stale word
    lanes_o <= ~w.data;
    flags_o <= ~w.flags;
    @(posedge clk_sys_i);
  endtask
  task automatic recv(output bdp_word_t w);
    int n;
    logic got;
    got = 1'b0;
    oen_o <= 1'b1;
    for (n = 0; n < 400 && !lanes_oe_i; n++) @(posedge clk_sys_i);
    w = {oflags_i, lanes_i};
    for (n = 0; n < 400 && !got; n++) begin
      @(posedge clk_sys_i);
      got = ack_i;
    end
    oen_o <= 1'b0;
    // Let the enable fall through the synchroniser before the next word
    repeat (4) @(posedge clk_sys_i);
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the bulk data DMA port
`timescale 1ns/1ps
`default_nettype none
module testbench import bdp_pkg::*; ;
  logic clk, rst, wr, rd, ocdis, tris, iclk_run, iclk, ien, oen, dack, ok, prev;
  logic oclk, oclk_oe, busy, busy_oe, avail, avail_oe, ack, ack_oe, lanes_oe;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, dut_lanes, ag_lanes, lanes, d;
  logic [2:0] ag_flags, oflags;
  bdp_word_t w;
  int failures, total_checks, cyc, i, n;
  longint e;
  assign lanes = lanes_oe ? dut_lanes : ag_lanes;
  bdp_dma_port u_bdp_dma_port (.clk_sys_i(clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .port_input_clock_i(iclk), .output_clock_disable_i(ocdis), .port_tristate_select_i(tris),
    .port_output_clock_o(oclk), .port_output_clock_oe_o(oclk_oe), .port_input_enable_i(ien),
    .port_output_enable_i(oen), .port_dma_ack_in_i(dack), .port_input_busy_o(busy),
    .port_input_busy_oe_o(busy_oe), .port_output_available_o(avail),
    .port_output_available_oe_o(avail_oe), .atapi_ack_out_o(ack), .atapi_ack_out_oe_o(ack_oe),
    .port_data_lanes_i(lanes), .port_data_lanes_o(dut_lanes), .port_data_lanes_oe_o(lanes_oe),
    .input_order_flags_i(ag_flags), .output_order_flags_o(oflags));
  // Undriven busy reads as busy, undriven acknowledge as idle
  bdp_agent_model u_bdp_agent_model (.clk_sys_i(clk), .iclk_run_i(iclk_run),
    .busy_i(busy_oe ? busy : 1'b1), .ack_i(ack_oe & ack), .lanes_oe_i(lanes_oe), .lanes_i(lanes),
    .oflags_i(oflags), .iclk_o(iclk), .ien_o(ien), .oen_o(oen), .dack_o(dack), .lanes_o(ag_lanes),
    .flags_o(ag_flags));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      failures++;
      results();
    end
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    ocdis = 1'b0;
    tris = 1'b1;
    iclk_run = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk(16'(busy_oe), 16'h0000);
    chk(16'(ack_oe), 16'h0000);
    wr_reg(BDP_ADDR_PORTRST, 16'h0002);
    @(posedge clk);
    chk(16'(avail_oe), 16'h0001);
    rd_reg(8'h00, d);
    chk(d, 16'h0000);
    $display("test 1 done");
    for (i = 0; i < 2; i++) begin
      wr_reg(BDP_ADDR_CTRL, 16'h0004 | 16'(i));
      rd_reg(BDP_ADDR_CTRL, d);
      chk(d, 16'h0004 | 16'(i));
      chk(16'(avail), 16'(i));
    end
    $display("test 2 done");
    wr_reg(BDP_ADDR_CTRL, 16'h0000);
    for (i = 0; i < 8; i++) begin
      u_bdp_agent_model.send({i[2:0], 16'ha000 + 16'(i)}, i[0], ok);
      chk(16'(ok), 16'h0001);
    end
    repeat (3) @(posedge clk);
    chk(16'(busy), 16'h0001);
    for (i = 0; i < 8; i++) begin
      rd_reg(BDP_ADDR_STATUS, d);
      chk(16'(d[6:4]), 16'(i));
      rd_reg(BDP_ADDR_DATA, d);
      chk(d, 16'ha000 + 16'(i));
    end
    $display("test 3 done");
    for (i = 0; i < 3; i++) begin
      wr_reg(BDP_ADDR_CTRL, 16'h0001 | 16'(i << 4));
      wr_reg(BDP_ADDR_DATA, 16'hc000 + 16'(i));
    end
    for (i = 0; i < 3; i++) begin
      u_bdp_agent_model.recv(w);
      chk(w.data, 16'hc000 + 16'(i));
      chk(16'(w.flags), 16'(i));
    end
    $display("test 4 done");
    wr_reg(BDP_ADDR_CTRL, 16'h0002);
    iclk_run <= 1'b1;
    for (i = 0; i < 2; i++) begin
      u_bdp_agent_model.send({3'h6, 16'h3c00 + 16'(i)}, 1'b0, ok);
      chk(16'(ok), 16'h0001);
    end
    iclk_run <= 1'b0;
    repeat (40) @(posedge clk);
    // Output clock keeps running here, yet no word may be taken
    u_bdp_agent_model.send({3'h1, 16'h7777}, 1'b1, ok);
    chk(16'(ok), 16'h0000);
    for (i = 0; i < 2; i++) begin
      rd_reg(BDP_ADDR_DATA, d);
      chk(d, 16'h3c00 + 16'(i));
    end
    rd_reg(BDP_ADDR_STATUS, d);
    chk(16'(d[0]), 16'h0000);
    $display("test 5 done");
    ocdis <= 1'b1;
    repeat (5) @(posedge clk);
    chk(16'(oclk_oe), 16'h0000);
    chk(16'(oclk), 16'h0000);
    ocdis <= 1'b0;
    repeat (5) @(posedge clk);
    n = 0;
    prev = oclk;
    repeat (400) begin
      @(posedge clk);
      if (oclk && !prev) n++;
      prev = oclk;
    end
    e = 400 * BDP_PHY_CLK_KHZ / (BDP_SYS_CLK_KHZ * 2 * BDP_OCLK_HALF);
    chk(16'(n >= e && n <= e + 1), 16'h0001);
    $display("test 6 done");
    results();
  end
endmodule
`default_nettype wire
